// File: hdl/iapm_pkg.sv
/*
  shared constants and carriers for the irq / power pin function mux.
  assumes a classic wishbone master on the same 20 MHz clock.
*/
package iapm_pkg;
  // register word offsets (byte addresses)
  localparam logic [3:0] IAPM_OFS_HOST = 4'h0;
  localparam logic [3:0] IAPM_OFS_POWER = 4'h4;
  localparam logic [3:0] IAPM_OFS_CHIP = 4'h8;
  localparam logic [3:0] IAPM_OFS_STATUS = 4'hc;
  // reset values
  localparam logic [7:0] IAPM_HOST_RST = 8'h00;
  localparam logic [7:0] IAPM_POWER_RST = 8'h00;
  localparam logic [7:0] IAPM_CHIP_RST = 8'h00;
  // field positions
  localparam int IAPM_IRQ14_LSB = 0;
  localparam int IAPM_IRQ15_LSB = 2;
  localparam int IAPM_RING_LSB = 1;
  localparam int IAPM_POFF_LSB = 3;
  localparam int IAPM_SUPPLY_BIT = 5;
  localparam int IAPM_PANEL_LSB = 6;
  localparam int IAPM_CLKSEL_BIT = 5;
  localparam int IAPM_ADDRESS_DECODE_OUTPUT_BIT = 0;
  localparam int IAPM_ADDRESS_WRITE_ENABLE_OUTPUT_BIT = 1;
  localparam int IAPM_KEYBOARD_RESET_BIT = 2;
  // function codes of a two bit select field
  typedef enum logic [1:0] {
    IAPM_SEL_NATIVE = 2'b00,
    IAPM_SEL_PORT = 2'b01,
    IAPM_SEL_ALT = 2'b10,
    IAPM_SEL_UART3 = 2'b11
  } iapm_sel_t;
  // one output pin: level and enable
  typedef struct packed {
    logic val;
    logic oe;
  } iapm_pin_t;
endpackage : iapm_pkg

// File: hdl/iapm_mux.sv
/*
  pin function mux for irq14, irq15, phone ring, power off, supply control
  and panel switch pins, with its wishbone register file.
  assumes pins arrive asynchronously and peripheral signals on clk_i.
*/
`timescale 1ns/1ps
module iapm_mux
  import iapm_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // functions behind the pins
  input wire logic irq14_req_i,
  input wire logic irq15_req_i,
  input wire logic [3:0] port1_out_i, // bit4,bit5 drive; index 0 bit4, 1 bit5
  input wire logic [3:0] port2_out_i, // port2 bits 0..3 drive levels
  input wire logic [3:0] port2_oe_i, // port2 drive enables
  input wire logic [1:0] port1_oe_i, // port1 bit4/bit5 enables
  input wire logic address_decode_output_i,
  input wire logic address_write_enable_output_i,
  input wire logic power_led_output_i,
  input wire logic watchdog_output_i,
  input wire logic infrared_select_one_i,
  input wire logic infrared_select_two_i,
  input wire logic keyboard_reset_i,
  input wire logic power_off_interrupt_i,
  input wire logic kbc_sixteen_out_i,
  input wire logic kbc_sixteen_oe_i,
  input wire logic main_power_i, // main power present
  input wire logic supply_off_cmd_i, // power down command
  // pins, three signals each, except the panel switch pin which is input only
  output logic irq14_pin_o,
  output logic irq14_pin_oe_o,
  input wire logic irq14_pin_i,
  output logic irq15_pin_o,
  output logic irq15_pin_oe_o,
  input wire logic irq15_pin_i,
  output logic ring_pin_o,
  output logic ring_pin_oe_o,
  input wire logic ring_pin_i,
  output logic poff_pin_o,
  output logic poff_pin_oe_o,
  input wire logic poff_pin_i,
  output logic supply_pin_o,
  output logic supply_pin_oe_o,
  input wire logic supply_pin_i,
  input wire logic panel_pin_i,
  // sampled values to the functions
  output logic [5:0] port_in_o, // p1b4,p1b5,p2b0..p2b3
  output logic kbc_sixteen_in_o,
  output logic uart3_ring_input_o,
  output logic uart3_carrier_detect_o,
  output logic clk_is_24mhz_o,
  output logic power_on_request_o,
  output logic power_off_request_o
);
  // the agreement filter below is written for exactly three stages
  if (SYNC_STAGES != 3) begin : g_stage_check
    $error("SYNC_STAGES must be 3");
  end

  // registers
  logic [7:0] host_pin_function_select_q;
  logic [7:0] power_pin_function_select_q;
  logic [7:0] chip_configuration_word_q;
  logic supply_on_q; // supply control level
  logic ack_q;

  // field decode
  wire iapm_sel_t s14 = iapm_sel_t'(host_pin_function_select_q[IAPM_IRQ14_LSB +: 2]);
  wire iapm_sel_t s15 = iapm_sel_t'(host_pin_function_select_q[IAPM_IRQ15_LSB +: 2]);
  wire iapm_sel_t sring = iapm_sel_t'(power_pin_function_select_q[IAPM_RING_LSB +: 2]);
  wire iapm_sel_t spoff = iapm_sel_t'(power_pin_function_select_q[IAPM_POFF_LSB +: 2]);
  wire iapm_sel_t spanel = iapm_sel_t'(power_pin_function_select_q[IAPM_PANEL_LSB +: 2]);
  wire supply_is_port = power_pin_function_select_q[IAPM_SUPPLY_BIT];
  wire use_address_decode_output = chip_configuration_word_q[IAPM_ADDRESS_DECODE_OUTPUT_BIT];
  wire use_address_write_enable_output = chip_configuration_word_q[IAPM_ADDRESS_WRITE_ENABLE_OUTPUT_BIT];
  wire use_keyboard_reset = chip_configuration_word_q[IAPM_KEYBOARD_RESET_BIT];

  // input synchronisers: three stages, change on agreement of 2nd and 3rd
  logic [2:0] s1_q, s2_q, s3_q; // ring, panel, poff
  logic [2:0] clean_q; // filtered levels
  logic [2:0] s1_irq_q, s2_irq_q, s3_irq_q; // irq14, irq15, supply pins
  logic [2:0] clean_irq_q;
  wire [2:0] raw_a = {poff_pin_i, panel_pin_i, ring_pin_i};
  wire [2:0] raw_b = {supply_pin_i, irq15_pin_i, irq14_pin_i};
  wire [2:0] agree_a = ~(s2_q ^ s3_q);
  wire [2:0] agree_b = ~(s2_irq_q ^ s3_irq_q);
  wire [2:0] clean_d = (agree_a & s3_q) | (~agree_a & clean_q);
  wire [2:0] clean_irq_d = (agree_b & s3_irq_q) | (~agree_b & clean_irq_q);

  // pins are pulled high idle, so filters reset to one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 3'h7; s2_q <= 3'h7; s3_q <= 3'h7; clean_q <= 3'h7;
      s1_irq_q <= 3'h7; s2_irq_q <= 3'h7; s3_irq_q <= 3'h7; clean_irq_q <= 3'h7;
    end else begin
      s1_q <= raw_a; s2_q <= s1_q; s3_q <= s2_q; clean_q <= clean_d;
      s1_irq_q <= raw_b; s2_irq_q <= s1_irq_q; s3_irq_q <= s2_irq_q; clean_irq_q <= clean_irq_d;
    end
  end

  // edge detection on filtered levels
  logic ring_prev_q, panel_prev_q;
  wire ring_mode = (sring == IAPM_SEL_NATIVE);
  wire panel_mode = (spanel == IAPM_SEL_NATIVE);
  // ring is active low; each falling edge is one wake pulse
  wire ring_wake = ring_mode && ring_prev_q && !clean_q[0];
  wire panel_fall = panel_mode && panel_prev_q && !clean_q[1];
  wire on_req = panel_fall && !main_power_i;
  wire off_req = panel_fall && main_power_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ring_prev_q <= 1'b1;
      panel_prev_q <= 1'b1;
    end else begin
      ring_prev_q <= clean_q[0];
      panel_prev_q <= clean_q[1];
    end
  end

  // supply on latch: wake or switch-on sets, command or switch-off clears; set wins
  wire supply_on_d = (ring_wake || on_req) ? 1'b1 :
                     (off_req || supply_off_cmd_i) ? 1'b0 : supply_on_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) supply_on_q <= 1'b0;
    else supply_on_q <= supply_on_d;
  end

  // irq14 pin selection
  always_comb begin
    irq14_pin_o = 1'b0;
    irq14_pin_oe_o = 1'b1;
    unique case (s14)
      IAPM_SEL_NATIVE: irq14_pin_o = irq14_req_i;
      IAPM_SEL_PORT: begin
        irq14_pin_o = use_address_decode_output ? address_decode_output_i : port1_out_i[0];
        irq14_pin_oe_o = use_address_decode_output | port1_oe_i[0];
      end
      IAPM_SEL_ALT: irq14_pin_o = power_led_output_i;
      IAPM_SEL_UART3: irq14_pin_o = infrared_select_one_i;
    endcase
  end

  // irq15 pin selection
  always_comb begin
    irq15_pin_o = 1'b0;
    irq15_pin_oe_o = 1'b1;
    unique case (s15)
      IAPM_SEL_NATIVE: irq15_pin_o = irq15_req_i;
      IAPM_SEL_PORT: begin
        irq15_pin_o = use_address_write_enable_output ? address_write_enable_output_i : port1_out_i[1];
        irq15_pin_oe_o = use_address_write_enable_output | port1_oe_i[1];
      end
      IAPM_SEL_ALT: irq15_pin_o = watchdog_output_i;
      IAPM_SEL_UART3: irq15_pin_o = infrared_select_two_i;
    endcase
  end

  // phone ring pin: driven only in port mode, by port bit or keyboard reset; input otherwise
  wire ring_port = (sring == IAPM_SEL_PORT);
  assign ring_pin_o = use_keyboard_reset ? keyboard_reset_i : port2_out_i[0];
  assign ring_pin_oe_o = ring_port & (use_keyboard_reset | port2_oe_i[0]);

  // power off pin selection
  always_comb begin
    poff_pin_o = 1'b0;
    poff_pin_oe_o = 1'b0;
    unique case (spoff)
      IAPM_SEL_NATIVE: begin
        poff_pin_o = power_off_interrupt_i;
        poff_pin_oe_o = 1'b1;
      end
      IAPM_SEL_PORT: begin
        poff_pin_o = port2_out_i[1];
        poff_pin_oe_o = port2_oe_i[1];
      end
      IAPM_SEL_ALT: begin
        poff_pin_o = kbc_sixteen_out_i;
        poff_pin_oe_o = kbc_sixteen_oe_i;
      end
      IAPM_SEL_UART3: poff_pin_oe_o = 1'b0; // input only
    endcase
  end

  // supply control pin
  assign supply_pin_o = supply_is_port ? port2_out_i[2] : supply_on_q;
  assign supply_pin_oe_o = supply_is_port ? port2_oe_i[2] : 1'b1;

  // samples back to functions; unselected ones see idle high
  assign port_in_o[0] = (s14 == IAPM_SEL_PORT) ? clean_irq_q[0] : 1'b1;
  assign port_in_o[1] = (s15 == IAPM_SEL_PORT) ? clean_irq_q[1] : 1'b1;
  assign port_in_o[2] = ring_port ? clean_q[0] : 1'b1;
  assign port_in_o[3] = (spoff == IAPM_SEL_PORT) ? clean_q[2] : 1'b1;
  assign port_in_o[4] = supply_is_port ? clean_irq_q[2] : 1'b1;
  assign port_in_o[5] = (spanel == IAPM_SEL_PORT) ? clean_q[1] : 1'b1;
  assign kbc_sixteen_in_o = (spoff == IAPM_SEL_ALT) ? clean_q[2] : 1'b1;
  assign uart3_ring_input_o = (spoff == IAPM_SEL_UART3) ? clean_q[2] : 1'b1;
  assign uart3_carrier_detect_o = (spanel == IAPM_SEL_UART3) ? clean_q[1] : 1'b1;
  assign clk_is_24mhz_o = chip_configuration_word_q[IAPM_CLKSEL_BIT];
  assign power_on_request_o = on_req;
  assign power_off_request_o = off_req;

  // wishbone decode
  wire req = cyc_i && stb_i && !ack_q;
  // a write lands at the edge where the master samples ack high, the same edge
  // at which it ends the cycle, so register and master agree on when it happened
  wire wr = cyc_i && stb_i && ack_q && we_i && sel_i[0];
  wire hit_host = adr_i == IAPM_OFS_HOST;
  wire hit_power = adr_i == IAPM_OFS_POWER;
  wire hit_chip = adr_i == IAPM_OFS_CHIP;
  wire hit_status = adr_i == IAPM_OFS_STATUS;
  wire [7:0] status_val = {4'h0, clean_q[1], main_power_i, clean_q[0], supply_on_q};
  wire [7:0] rd_val = hit_host ? host_pin_function_select_q :
                      hit_power ? power_pin_function_select_q :
                      hit_chip ? chip_configuration_word_q :
                      hit_status ? status_val : 8'h00;

  // register writes, one cycle ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_pin_function_select_q <= IAPM_HOST_RST;
      power_pin_function_select_q <= IAPM_POWER_RST;
      chip_configuration_word_q <= IAPM_CHIP_RST;
      ack_q <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req) dat_o <= {24'h00_0000, rd_val};
      if (wr && hit_host) host_pin_function_select_q <= dat_i[7:0];
      if (wr && hit_power) power_pin_function_select_q <= dat_i[7:0];
      if (wr && hit_chip) chip_configuration_word_q <= dat_i[7:0];
    end
  end
  assign ack_o = ack_q;

  // checks
  AST_IRQ14_NATIVE: assert property (@(posedge clk_i) disable iff (rst_i)
    (s14 == IAPM_SEL_NATIVE) |-> (irq14_pin_o == irq14_req_i && irq14_pin_oe_o))
    else $error("irq14 pin not carrying request");
  AST_IRQ15_WDT: assert property (@(posedge clk_i) disable iff (rst_i)
    (s15 == IAPM_SEL_ALT) |-> (irq15_pin_o == watchdog_output_i))
    else $error("irq15 pin not carrying watchdog");
  AST_ADDRESS_DECODE_OUTPUT: assert property (@(posedge clk_i) disable iff (rst_i)
    (s14 == IAPM_SEL_PORT && use_address_decode_output) |-> (irq14_pin_o == address_decode_output_i))
    else $error("decode output not on irq14 pin");
  AST_ADDRESS_WRITE_ENABLE_OUTPUT: assert property (@(posedge clk_i) disable iff (rst_i)
    (s15 == IAPM_SEL_PORT && use_address_write_enable_output) |-> (irq15_pin_o == address_write_enable_output_i))
    else $error("write enable not on irq15 pin");
  AST_CLKSEL: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_chip) |=> (clk_is_24mhz_o == $past(dat_i[IAPM_CLKSEL_BIT])))
    else $error("clock select not updated");
  AST_RING_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
    (ring_mode && $fell(clean_q[0]) && !supply_is_port) |=> supply_pin_o)
    else $error("ring pulse did not switch supply on");
  AST_POFF_OE: assert property (@(posedge clk_i) disable iff (rst_i)
    (spoff == IAPM_SEL_UART3) |-> !poff_pin_oe_o)
    else $error("power off pin driven in uart mode");
  AST_SUPPLY: assert property (@(posedge clk_i) disable iff (rst_i)
    !supply_is_port |-> (supply_pin_o == supply_on_q && supply_pin_oe_o))
    else $error("supply pin wrong");
  AST_PANEL: assert property (@(posedge clk_i) disable iff (rst_i)
    (panel_mode && $fell(clean_q[1])) |-> (power_on_request_o == !main_power_i))
    else $error("panel edge misread");
  AST_RING_OE: assert property (@(posedge clk_i) disable iff (rst_i)
    ring_mode |-> !ring_pin_oe_o)
    else $error("ring pin driven while input");

  // further checks: irq14 led, irq15 and power off native codes, keyboard reset, panel edges and non-switch codes, unselected inputs
  AST_IRQ14_LED: assert property (@(posedge clk_i) disable iff (rst_i)
    (s14 == IAPM_SEL_ALT) |-> (irq14_pin_o == power_led_output_i && irq14_pin_oe_o))
    else $error("irq14 pin not carrying power led");
  AST_IRQ15_NATIVE: assert property (@(posedge clk_i) disable iff (rst_i)
    (s15 == IAPM_SEL_NATIVE) |-> (irq15_pin_o == irq15_req_i && irq15_pin_oe_o))
    else $error("irq15 pin not carrying request");
  AST_KEYBOARD_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    (ring_port && use_keyboard_reset) |-> (ring_pin_o == keyboard_reset_i && ring_pin_oe_o))
    else $error("keyboard reset not on ring pin");
  AST_POFF_NATIVE: assert property (@(posedge clk_i) disable iff (rst_i)
    (spoff == IAPM_SEL_NATIVE) |-> (poff_pin_o == power_off_interrupt_i && poff_pin_oe_o))
    else $error("power off pin not carrying interrupt");
  AST_PANEL_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    (panel_mode && $fell(clean_q[1])) |-> (power_off_request_o == main_power_i))
    else $error("panel edge misread as off");
  AST_PANEL_PORT: assert property (@(posedge clk_i) disable iff (rst_i)
    !panel_mode |-> !(power_on_request_o || power_off_request_o))
    else $error("panel request while pin not a switch");
  AST_UNSEL_RING: assert property (@(posedge clk_i) disable iff (rst_i)
    (spoff != IAPM_SEL_UART3) |-> uart3_ring_input_o)
    else $error("uart3 ring input active while unselected");
endmodule // iapm_mux

// File: testbench/iapm_partner.sv
/*
  far side of the power pins: main supply, panel switch and phone line.
  assumes commands from the bench arrive as one-cycle pulses on clk_i.
*/
`timescale 1ns/1ps
module iapm_partner
  import iapm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic supply_i, // on/off command level on the wire
  input wire logic press_i, // bench asks for a switch press
  input wire logic ring_i, // bench asks for a ring pulse
  output logic main_power_o,
  output logic panel_o,
  output logic ring_o
);
  logic [3:0] pwr_q; // supply ramp, main power lags the command
  logic [3:0] pan_q; // cycles left of the press
  logic [3:0] rng_q; // cycles left of the ring pulse
  // supply ramps slowly, switch and line hold low long enough for the filter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q <= '0;
      pan_q <= '0;
      rng_q <= '0;
    end else begin
      pwr_q <= {pwr_q[2:0], supply_i};
      pan_q <= press_i ? 4'h8 : (pan_q != 4'h0) ? pan_q - 4'h1 : 4'h0;
      rng_q <= ring_i ? 4'h6 : (rng_q != 4'h0) ? rng_q - 4'h1 : 4'h0;
    end
  end
  assign main_power_o = pwr_q[3];
  assign panel_o = (pan_q == 4'h0); // pulled up when released
  assign ring_o = (rng_q == 4'h0); // active low ring
endmodule // iapm_partner

// File: testbench/testbench.sv
/*
  bench for the pin function mux: wishbone access, select tables, power events.
  assumes iapm_mux and iapm_partner are compiled before it.
*/
`timescale 1ns/1ps
module testbench
  import iapm_pkg::*;
();
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] wdat = '0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [3:0] s = '0; // function sources, one bit per select code
  logic [3:0] f = '0; // decode, write enable, kb reset, off command
  logic p20 = 1'b0, p22 = 1'b0, press = 1'b0, ring = 1'b0, poff_ext = 1'b1;
  logic i14, i14e, i15, i15e, rg, rge, pf, pfe, sp, spe, u3ri, u3cd, clk24, pon, poff, mpw, pan, rline, k16;
  logic [5:0] pin_in;
  logic [3:0] pat [2] = '{4'h5, 4'ha};
  int failures = 0, checked = 0, n_on = 0, n_off = 0;
  always #25 clk_i = ~clk_i;
  iapm_mux dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .irq14_req_i(s[0]), .irq15_req_i(s[0]),
    .port1_out_i({2'h0, s[1], s[1]}), .port2_out_i({p22, p22, s[1], p20}), .port2_oe_i(4'hf),
    .port1_oe_i(2'h3), .address_decode_output_i(f[0]), .address_write_enable_output_i(f[1]),
    .power_led_output_i(s[2]), .watchdog_output_i(s[2]), .infrared_select_one_i(s[3]),
    .infrared_select_two_i(s[3]), .keyboard_reset_i(f[2]), .power_off_interrupt_i(s[0]),
    .kbc_sixteen_out_i(s[2]), .kbc_sixteen_oe_i(1'h1), .main_power_i(mpw), .supply_off_cmd_i(f[3]),
    .irq14_pin_o(i14), .irq14_pin_oe_o(i14e), .irq14_pin_i(i14e ? i14 : 1'b1),
    .irq15_pin_o(i15), .irq15_pin_oe_o(i15e), .irq15_pin_i(i15e ? i15 : 1'b1),
    .ring_pin_o(rg), .ring_pin_oe_o(rge), .ring_pin_i(rge ? rg : rline),
    .poff_pin_o(pf), .poff_pin_oe_o(pfe), .poff_pin_i(pfe ? pf : poff_ext),
    .supply_pin_o(sp), .supply_pin_oe_o(spe), .supply_pin_i(spe ? sp : 1'b0), .panel_pin_i(pan),
    .port_in_o(pin_in), .kbc_sixteen_in_o(k16), .uart3_ring_input_o(u3ri), .uart3_carrier_detect_o(u3cd),
    .clk_is_24mhz_o(clk24), .power_on_request_o(pon), .power_off_request_o(poff));
  iapm_partner far_u (.clk_i(clk_i), .rst_i(rst_i), .supply_i(spe & sp), .press_i(press), .ring_i(ring),
    .main_power_o(mpw), .panel_o(pan), .ring_o(rline));
  // request pulses are one cycle wide, counted where settled
  always @(negedge clk_i) begin
    n_on += (pon === 1'b1);
    n_off += (poff === 1'b1);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle, held until ack, idle cycle before the next
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] m,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= m;
    wdat <= {24'h00_0000, d};
    do begin
      @(negedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    if (n >= 100) failures++;
    @(posedge clk_i);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, 4'hf, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, 4'hf, q);
    chk(q, e);
  endtask
  // switch press or ring pulse, then settle past the input filter
  task automatic poke(input logic is_ring, input int n);
    @(posedge clk_i);
    if (is_ring) ring <= 1'b1;
    else press <= 1'b1;
    @(posedge clk_i);
    ring <= 1'b0;
    press <= 1'b0;
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    logic [7:0] junk;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IAPM_OFS_HOST, 8'h00);
    rd(IAPM_OFS_POWER, 8'h00);
    rd(IAPM_OFS_CHIP, 8'h00);
    wr(4'h2, 8'hff);
    rd(4'h2, 8'h00);
    // a write with lane 0 disabled must leave the register alone
    wb(1'b1, IAPM_OFS_HOST, 8'hff, 4'h0, junk);
    rd(IAPM_OFS_HOST, 8'h00);
    $display("test reset done");
    // every code of both host fields and the power off field, both levels
    for (int c = 0; c < 4; c++) begin
      wr(IAPM_OFS_HOST, 8'(c * 5));
      wr(IAPM_OFS_POWER, 8'(c << 3));
      foreach (pat[i]) begin
        @(posedge clk_i);
        s <= pat[i];
        poff_ext <= pat[i][3];
        repeat (6) @(negedge clk_i);
        chk(i14, pat[i][c]);
        chk(i15, pat[i][c]);
        chk(c == 3 ? u3ri : pf, pat[i][c]);
        chk(pfe, c != 3);
        chk(pin_in[0], c == 1 ? pat[i][1] : 1'b1);
        chk(u3ri, c == 3 ? pat[i][3] : 1'b1);
        chk({pin_in[3], pin_in[1]}, c == 1 ? {2{pat[i][1]}} : 2'h3);
        chk(k16, c == 2 ? pat[i][2] : 1'b1);
        chk({i14e, i15e}, 2'h3);
      end
    end
    $display("test select tables done");
    wr(IAPM_OFS_CHIP, 8'h23);
    wr(IAPM_OFS_HOST, 8'h05);
    @(posedge clk_i);
    s <= 4'h2; // port bits high, decode outputs low
    @(negedge clk_i);
    chk(i14, 1'b0);
    chk(i15, 1'b0);
    chk(clk24, 1'b1);
    rd(IAPM_OFS_CHIP, 8'h23);
    wr(IAPM_OFS_POWER, 8'h22);
    @(posedge clk_i);
    f <= 4'h4;
    p22 <= 1'b1;
    @(negedge clk_i);
    chk({rge, rg}, 2'h2);
    chk({spe, sp}, 2'h3);
    repeat (4) @(negedge clk_i);
    chk(pin_in[2], 1'b0);
    wr(IAPM_OFS_CHIP, 8'h27);
    @(negedge clk_i);
    chk(rg, 1'b1);
    $display("test port options done");
    // power events, power selects at their defaults, then panel as port and as uart3 input
    wr(IAPM_OFS_POWER, 8'h00);
    poke(1'b0, 20);
    chk(sp, 1'b1);
    chk(n_on, 1);
    rd(IAPM_OFS_STATUS, 8'h0f);
    poke(1'b0, 20);
    chk(sp, 1'b0);
    chk(n_off, 1);
    poke(1'b1, 20);
    chk(sp, 1'b1);
    wr(IAPM_OFS_POWER, 8'h40);
    poke(1'b0, 6);
    chk(pin_in[5], 1'b0);
    repeat (20) @(negedge clk_i);
    chk({sp, 4'(n_off)}, 5'h11);
    wr(IAPM_OFS_POWER, 8'hc0);
    poke(1'b0, 6);
    chk(u3cd, 1'b0);
    $display("test power events done");
    wrap_up;
  end
  // cuts a hang short well past the expected run of about 230 cycles
  initial begin
    repeat (8000) @(posedge clk_i);
    failures++;
    wrap_up;
  end
endmodule // testbench
